// ==== bit_error_tester_pkg.sv ====
// Package for the serial link bit error tester: register map, field layout, enumerations, timing.
// Assumes a single 100 MHz system clock and a plain address/strobe register port.
package bit_error_tester_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_CH      = 4;
	localparam int DATA_W      = 32;
	localparam int CNT_W       = 48;
	localparam int FREQ_W      = 24;
	localparam int ADDR_W      = 8;
	localparam int CFG_ADDR_W  = 6;

	// ==========================================================
	// Global register offsets (byte addresses, one word each)
	localparam logic [7:0] OFF_GROUP_CTRL  = 8'h00;
	localparam logic [7:0] OFF_GROUP_STAT  = 8'h04;
	localparam logic [7:0] OFF_CFG_ADDR    = 8'h08;
	localparam logic [7:0] OFF_CFG_DATA    = 8'h0c;
	localparam logic [7:0] OFF_PORT_CTRL   = 8'h10;
	localparam logic [7:0] OFF_PORT_STAT   = 8'h14;
	localparam logic [7:0] OFF_MEAS_WIN    = 8'h18;
	// Per-channel blocks start here, stride 0x20.
	localparam logic [7:0] OFF_CH_BASE     = 8'h40;
	localparam logic [7:0] CH_STRIDE       = 8'h20;
	localparam logic [4:0] CH_CTRL         = 5'h00;
	localparam logic [4:0] CH_ANALOG       = 5'h04;
	localparam logic [4:0] CH_STAT         = 5'h08;
	localparam logic [4:0] CH_BITS_LO      = 5'h0c;
	localparam logic [4:0] CH_BITS_HI      = 5'h10;
	localparam logic [4:0] CH_ERRS_LO      = 5'h14;
	localparam logic [4:0] CH_ERRS_HI      = 5'h18;
	localparam logic [4:0] CH_FREQ         = 5'h1c;

	// ==========================================================
	// Field positions
	localparam int F_GRP_RESET   = 0;
	localparam int F_CH_LOOP     = 0;
	localparam int F_CH_TXPAT    = 4;
	localparam int F_CH_RXPAT    = 8;
	localparam int F_CH_INJECT   = 12;
	localparam int F_CH_CNT_CLR  = 13;
	localparam int F_ST_LOCK     = 0;
	localparam int F_ST_RATE     = 8;

	// ==========================================================
	// Reset values and timing
	localparam logic [DATA_W-1:0] RST_ANALOG   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_PORT     = 32'h0000_0000;
	localparam logic [DATA_W-1:0] BUS_UNMAPPED = 32'h0000_0000;
	localparam int    SYS_CLK_HZ      = 100_000_000;
	localparam int    MEAS_WIN_US     = 100;
	localparam int    MEAS_WIN_CYC    = SYS_CLK_HZ / 1_000_000 * MEAS_WIN_US;
	localparam int    GRP_RESET_NS    = 160;
	localparam int    GRP_RESET_CYC   = (GRP_RESET_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int    LOCK_GOOD_WORDS = 64;
	localparam int    LOCK_BAD_WORDS  = 16;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		LOOP_NONE,
		LOOP_NEAR_PCS,
		LOOP_FAR_PCS
	} loop_t;

	typedef enum logic [2:0] {
		PAT_PRBS7,
		PAT_PRBS15,
		PAT_PRBS23,
		PAT_PRBS31,
		PAT_CLK2X,
		PAT_CLK10X
	} pattern_t;

	// Signals toward and from one serial transceiver channel.
	typedef struct packed {
		logic [DATA_W-1:0] tx_data;
		logic [1:0]        loopback;
		logic [7:0]        tx_swing;
		logic [7:0]        tx_pre;
		logic [7:0]        tx_post;
		logic [7:0]        rx_eq;
	} xcvr_ctrl_t;

	typedef struct packed {
		logic              rx_valid;
		logic [DATA_W-1:0] rx_data;
		logic              tx_user_clock_out_tick;
		logic              rx_user_clock_out_tick;
	} xcvr_stat_t;

	// Register port carrier.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

endpackage

// ==== serial_link_bit_error_tester.sv ====
// Bit error ratio test logic for a group of four serial transceiver channels.
// Assumes one system clock; transceiver user clocks arrive as synchronous tick pulses and
// the dynamic reconfiguration port answers writes immediately.
`timescale 1ns/1ps

module serial_link_bit_error_tester #(
	parameter int NUM_CH       = bit_error_tester_pkg::NUM_CH,
	parameter int MEAS_WIN_CYC = bit_error_tester_pkg::MEAS_WIN_CYC
) (
	input  wire logic                          clk,
	input  wire logic                          srst,
	input  wire bit_error_tester_pkg::bus_req_t            bus_req,
	output logic [bit_error_tester_pkg::DATA_W-1:0]        bus_rdata,
	input  wire logic                          pll_locked,
	input  wire bit_error_tester_pkg::xcvr_stat_t [3:0]    xcvr_stat,
	output bit_error_tester_pkg::xcvr_ctrl_t [3:0]         xcvr_ctrl,
	output logic [3:0]                         xcvr_reset,
	output logic                               cfg_wr,
	output logic [bit_error_tester_pkg::CFG_ADDR_W-1:0]    cfg_addr,
	output logic [15:0]                        cfg_wdata,
	input  wire logic [15:0]                   cfg_rdata,
	output logic [15:0]                        port_ctrl,
	input  wire logic [15:0]                   port_stat
);

	localparam int DW = bit_error_tester_pkg::DATA_W;
	localparam int CW = bit_error_tester_pkg::CNT_W;
	localparam int FW = bit_error_tester_pkg::FREQ_W;

	// ==========================================================
	// State
	typedef struct packed {
		logic [DW-1:0]          prbs;
		logic [2:0]             txpat;
		logic [2:0]             rxpat;
		logic [1:0]             loop;
		logic [31:0]            analog;
		logic                   inject;
		logic [CW-1:0]          bits;
		logic [CW-1:0]          errs;
		logic [DW-1:0]          chk;
		logic [6:0]             good;
		logic [4:0]             bad;
		logic                   locked;
		logic [FW-1:0]          tx_acc;
		logic [FW-1:0]          rx_acc;
		logic [FW-1:0]          tx_freq;
		logic [FW-1:0]          rx_freq;
		logic [DW-1:0]          tx_word;
	} chan_t;

	typedef struct packed {
		chan_t [3:0]            ch;
		logic [7:0]             grp_rst_cnt;
		logic [31:0]            win_cnt;
		logic [bit_error_tester_pkg::CFG_ADDR_W-1:0] cfg_addr;
		logic                   cfg_wr;
		logic [15:0]            cfg_wdata;
		logic [15:0]            port_ctrl;
		logic                   pll_locked;
		logic [DW-1:0]          rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// ==========================================================
	// Pattern step: one word of the selected sequence from the previous word.
	function automatic logic [DW-1:0] next_word(input logic [2:0] pat, input logic [DW-1:0] cur);
		logic [DW-1:0] s;
		logic          fb;
		s = cur;
		for (int i = 0; i < DW; i++) begin
			case (pat)
				bit_error_tester_pkg::PAT_PRBS7:  fb = s[6] ^ s[5];
				bit_error_tester_pkg::PAT_PRBS15: fb = s[14] ^ s[13];
				bit_error_tester_pkg::PAT_PRBS23: fb = s[22] ^ s[17];
				default:              fb = s[30] ^ s[27];
			endcase
			s = {s[DW-2:0], fb};
		end
		case (pat)
			bit_error_tester_pkg::PAT_CLK2X:  next_word = 32'haaaa_aaaa;
			bit_error_tester_pkg::PAT_CLK10X: next_word = 32'hffc0_0ffc;
			default:              next_word = (s == '0) ? 32'h0000_0001 : s;
		endcase
	endfunction

	function automatic logic [5:0] popcount(input logic [DW-1:0] v);
		popcount = '0;
		for (int i = 0; i < DW; i++) begin
			popcount = popcount + 6'(v[i]);
		end
	endfunction

	function automatic logic [CW-1:0] sat_add(input logic [CW-1:0] a, input logic [CW-1:0] b);
		logic [CW:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[CW] ? '1 : s[CW-1:0];
	endfunction

	// ==========================================================
	// Next state
	logic [7:0]  ch_off;
	logic [1:0]  ch_idx;
	logic [4:0]  ch_reg;
	logic        ch_hit;
	logic        win_end;

	always_comb begin
		logic [DW-1:0] exp_w;
		logic [DW-1:0] diff;
		exp_w = '0;
		diff = '0;
		st_nxt = st_r;
		st_nxt.cfg_wr = 1'b0;
		st_nxt.pll_locked = pll_locked;
		ch_off = bus_req.addr - bit_error_tester_pkg::OFF_CH_BASE;
		ch_idx = ch_off[6:5];
		ch_reg = ch_off[4:0];
		ch_hit = bus_req.addr >= bit_error_tester_pkg::OFF_CH_BASE && 8'(ch_off[7:5]) < 8'(NUM_CH);
		win_end = st_r.win_cnt == 32'(MEAS_WIN_CYC - 1);
		st_nxt.win_cnt = win_end ? '0 : st_r.win_cnt + 32'h0000_0001;
		if (st_r.grp_rst_cnt != '0) begin
			st_nxt.grp_rst_cnt = st_r.grp_rst_cnt - 8'h01;
		end

		for (int c = 0; c < 4; c++) begin
			// Transmit generator; a single bit flip on one word for error injection.
			st_nxt.ch[c].prbs = next_word(st_r.ch[c].txpat, st_r.ch[c].prbs);
			st_nxt.ch[c].tx_word = st_nxt.ch[c].prbs ^ {{(DW-1){1'b0}}, st_r.ch[c].inject};
			st_nxt.ch[c].inject = 1'b0;

			// Checker: self-synchronising, predicts next word from last received word.
			if (xcvr_stat[c].rx_valid) begin
				exp_w = next_word(st_r.ch[c].rxpat, st_r.ch[c].chk);
				diff = exp_w ^ xcvr_stat[c].rx_data;
				// Once locked, a bad word must not seed the next prediction, or one flipped bit
				// would echo into the following word and count as many errors.
				st_nxt.ch[c].chk = (st_r.ch[c].locked && diff != '0) ? exp_w : xcvr_stat[c].rx_data;
				// A burst of clean words is needed to call lock; a run of bad words drops it.
				if (diff == '0) begin
					st_nxt.ch[c].bad = '0;
					if (st_r.ch[c].good != 7'(bit_error_tester_pkg::LOCK_GOOD_WORDS)) begin
						st_nxt.ch[c].good = st_r.ch[c].good + 7'h01;
					end else begin
						st_nxt.ch[c].locked = 1'b1;
					end
				end else begin
					st_nxt.ch[c].good = '0;
					if (st_r.ch[c].bad != 5'(bit_error_tester_pkg::LOCK_BAD_WORDS)) begin
						st_nxt.ch[c].bad = st_r.ch[c].bad + 5'h01;
					end else begin
						st_nxt.ch[c].locked = 1'b0;
					end
				end
				st_nxt.ch[c].bits = sat_add(st_r.ch[c].bits, CW'(DW));
				st_nxt.ch[c].errs = sat_add(st_r.ch[c].errs, CW'(popcount(diff)));
			end

			// Frequency: count user clock ticks over a fixed system clock window.
			st_nxt.ch[c].tx_acc = st_r.ch[c].tx_acc + FW'(xcvr_stat[c].tx_user_clock_out_tick);
			st_nxt.ch[c].rx_acc = st_r.ch[c].rx_acc + FW'(xcvr_stat[c].rx_user_clock_out_tick);
			if (win_end) begin
				st_nxt.ch[c].tx_freq = st_nxt.ch[c].tx_acc;
				st_nxt.ch[c].rx_freq = st_nxt.ch[c].rx_acc;
				st_nxt.ch[c].tx_acc = '0;
				st_nxt.ch[c].rx_acc = '0;
			end
		end

		// Register writes.
		if (bus_req.wr) begin
			if (bus_req.addr == bit_error_tester_pkg::OFF_GROUP_CTRL) begin
				if (bus_req.wdata[bit_error_tester_pkg::F_GRP_RESET]) begin
					st_nxt.grp_rst_cnt = 8'(bit_error_tester_pkg::GRP_RESET_CYC);
				end
			end else if (bus_req.addr == bit_error_tester_pkg::OFF_CFG_ADDR) begin
				st_nxt.cfg_addr = bus_req.wdata[bit_error_tester_pkg::CFG_ADDR_W-1:0];
			end else if (bus_req.addr == bit_error_tester_pkg::OFF_CFG_DATA) begin
				st_nxt.cfg_wdata = bus_req.wdata[15:0];
				st_nxt.cfg_wr = 1'b1;
			end else if (bus_req.addr == bit_error_tester_pkg::OFF_PORT_CTRL) begin
				st_nxt.port_ctrl = bus_req.wdata[15:0];
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_CTRL) begin
				st_nxt.ch[ch_idx].loop = bus_req.wdata[bit_error_tester_pkg::F_CH_LOOP +: 2];
				st_nxt.ch[ch_idx].txpat = bus_req.wdata[bit_error_tester_pkg::F_CH_TXPAT +: 3];
				st_nxt.ch[ch_idx].rxpat = bus_req.wdata[bit_error_tester_pkg::F_CH_RXPAT +: 3];
				st_nxt.ch[ch_idx].inject = bus_req.wdata[bit_error_tester_pkg::F_CH_INJECT];
				if (bus_req.wdata[bit_error_tester_pkg::F_CH_CNT_CLR]) begin
					st_nxt.ch[ch_idx].bits = '0;
					st_nxt.ch[ch_idx].errs = '0;
				end
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_ANALOG) begin
				st_nxt.ch[ch_idx].analog = bus_req.wdata;
			end
		end

		// Register reads; data stands in the following cycle only.
		st_nxt.rdata = bit_error_tester_pkg::BUS_UNMAPPED;
		if (bus_req.rd) begin
			if (bus_req.addr == bit_error_tester_pkg::OFF_GROUP_STAT) begin
				st_nxt.rdata = {30'h0, st_r.grp_rst_cnt != '0, st_r.pll_locked};
			end else if (bus_req.addr == bit_error_tester_pkg::OFF_CFG_ADDR) begin
				st_nxt.rdata = 32'(st_r.cfg_addr);
			end else if (bus_req.addr == bit_error_tester_pkg::OFF_CFG_DATA) begin
				st_nxt.rdata = 32'(cfg_rdata);
			end else if (bus_req.addr == bit_error_tester_pkg::OFF_PORT_CTRL) begin
				st_nxt.rdata = 32'(st_r.port_ctrl);
			end else if (bus_req.addr == bit_error_tester_pkg::OFF_PORT_STAT) begin
				st_nxt.rdata = 32'(port_stat);
			end else if (bus_req.addr == bit_error_tester_pkg::OFF_MEAS_WIN) begin
				st_nxt.rdata = 32'(MEAS_WIN_CYC);
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_CTRL) begin
				st_nxt.rdata = {20'h0, 1'b0, st_r.ch[ch_idx].rxpat, 1'b0, st_r.ch[ch_idx].txpat,
					2'b00, st_r.ch[ch_idx].loop};
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_ANALOG) begin
				st_nxt.rdata = st_r.ch[ch_idx].analog;
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_STAT) begin
				// Line rate in ticks per window is shown only while locked.
				st_nxt.rdata = st_r.ch[ch_idx].locked ?
					{st_r.ch[ch_idx].rx_freq, 7'h0, 1'b1} : 32'h0000_0000;
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_BITS_LO) begin
				st_nxt.rdata = st_r.ch[ch_idx].bits[31:0];
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_BITS_HI) begin
				st_nxt.rdata = 32'(st_r.ch[ch_idx].bits[CW-1:32]);
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_ERRS_LO) begin
				st_nxt.rdata = st_r.ch[ch_idx].errs[31:0];
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_ERRS_HI) begin
				st_nxt.rdata = 32'(st_r.ch[ch_idx].errs[CW-1:32]);
			end else if (ch_hit && ch_reg == bit_error_tester_pkg::CH_FREQ) begin
				st_nxt.rdata = 32'(st_r.ch[ch_idx].tx_freq);
			end
		end

		// Group reset wipes generator and checker state, counters and lock; patterns, loopback, analog and rates are kept.
		if (st_r.grp_rst_cnt != '0) begin
			for (int c = 0; c < 4; c++) begin
				st_nxt.ch[c].bits = '0;
				st_nxt.ch[c].errs = '0;
				st_nxt.ch[c].locked = 1'b0;
				st_nxt.ch[c].good = '0;
				st_nxt.ch[c].bad = '0;
				st_nxt.ch[c].chk = '0;
				st_nxt.ch[c].prbs = 32'h0000_0001;
				st_nxt.ch[c].inject = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs; only configuration and analog controls leave the block, never the
	// pattern data paths themselves beyond the channel fabric bus.
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			xcvr_ctrl[c].tx_data = st_r.ch[c].tx_word;
			xcvr_ctrl[c].loopback = st_r.ch[c].loop;
			xcvr_ctrl[c].tx_swing = st_r.ch[c].analog[7:0];
			xcvr_ctrl[c].tx_pre = st_r.ch[c].analog[15:8];
			xcvr_ctrl[c].tx_post = st_r.ch[c].analog[23:16];
			xcvr_ctrl[c].rx_eq = st_r.ch[c].analog[31:24];
		end
	end

	assign bus_rdata  = st_r.rdata;
	assign xcvr_reset = {4{st_r.grp_rst_cnt != '0}};
	assign cfg_wr     = st_r.cfg_wr;
	assign cfg_addr   = st_r.cfg_addr;
	assign cfg_wdata  = st_r.cfg_wdata;
	assign port_ctrl  = st_r.port_ctrl;

endmodule

// ==== bit_error_tester_peer.sv ====
// Link peer model: loops every transmitted word back outside channel reset and holds the reconfiguration memory.
// Assumes the tester's clock; user clock ticks are derived from it.
`timescale 1ns/1ps

module bit_error_tester_peer (
	input  wire logic                       clk,
	input  wire bit_error_tester_pkg::xcvr_ctrl_t [3:0] xcvr_ctrl,
	input  wire logic [3:0]                 xcvr_reset,
	input  wire logic                       cfg_wr,
	input  wire logic [5:0]                 cfg_addr,
	input  wire logic [15:0]                cfg_wdata,
	output bit_error_tester_pkg::xcvr_stat_t [3:0]      xcvr_stat,
	output logic [15:0]                     cfg_rdata
);
	// ==========
	// Echo, ticks and memory
	logic [15:0] mem_r [64];
	logic [1:0]  tick_r = 2'h0;
	initial begin
		xcvr_stat = '0;
		foreach (mem_r[i]) mem_r[i] = 16'h0000;
	end
	// The far end loops the link, so words come back in every loopback mode.
	always @(posedge clk) begin
		tick_r <= tick_r + 2'h1;
		if (cfg_wr)
			mem_r[cfg_addr] <= cfg_wdata;
		for (int c = 0; c < 4; c++) begin
			// A channel in reset has released its line; flipping data keeps a stale word from passing.
			xcvr_stat[c].rx_valid <= !xcvr_reset[c];
			xcvr_stat[c].rx_data  <= xcvr_reset[c] ? ~xcvr_stat[c].rx_data : xcvr_ctrl[c].tx_data;
			xcvr_stat[c].tx_user_clock_out_tick <= tick_r[0];
			xcvr_stat[c].rx_user_clock_out_tick <= &tick_r;
		end
	end
	assign cfg_rdata = mem_r[cfg_addr];
endmodule

// ==== bit_error_tester_asserts.sv ====
// Checker for the bit error tester: relations between register traffic and outputs.
// Assumes it is bound into the tester and sees only its ports.
`timescale 1ns/1ps

module bit_error_tester_asserts #(
	parameter int NUM_CH       = 4,
	parameter int MEAS_WIN_CYC = 100
) (
	input wire logic                       clk,
	input wire logic                       srst,
	input wire bit_error_tester_pkg::bus_req_t         bus_req,
	input wire logic [31:0]                bus_rdata,
	input wire logic                       pll_locked,
	input wire bit_error_tester_pkg::xcvr_stat_t [3:0] xcvr_stat,
	input wire bit_error_tester_pkg::xcvr_ctrl_t [3:0] xcvr_ctrl,
	input wire logic [3:0]                 xcvr_reset,
	input wire logic                       cfg_wr,
	input wire logic [5:0]                 cfg_addr,
	input wire logic [15:0]                cfg_wdata,
	input wire logic [15:0]                cfg_rdata,
	input wire logic [15:0]                port_ctrl,
	input wire logic [15:0]                port_stat
);
	// ==========
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic       wr;
	logic       rd;
	logic [7:0] a;
	assign wr = bus_req.wr;
	assign rd = bus_req.rd;
	assign a  = bus_req.addr;
	a_group_reset_all: assert property (
		wr && a == bit_error_tester_pkg::OFF_GROUP_CTRL && bus_req.wdata[0] |=> (xcvr_reset == 4'hf)[*8])
		else $error("group reset not held on all channels");
	a_group_reset_end: assert property (
		$rose(xcvr_reset[0]) |-> ##[15:17] xcvr_reset == 4'h0) else $error("group reset length off");
	a_loop_select: assert property (
		wr && a == 8'h40 |=> xcvr_ctrl[0].loopback == $past(bus_req.wdata[1:0])) else $error("loopback not applied");
	a_analog_apply: assert property (
		wr && a == 8'h44 |=> {xcvr_ctrl[0].rx_eq, xcvr_ctrl[0].tx_post, xcvr_ctrl[0].tx_pre,
		xcvr_ctrl[0].tx_swing} == $past(bus_req.wdata)) else $error("analog controls not applied");
	a_cfg_write: assert property (
		wr && a == bit_error_tester_pkg::OFF_CFG_DATA |=> cfg_wr && cfg_wdata == $past(bus_req.wdata[15:0]))
		else $error("reconfiguration write missing");
	a_cfg_cause: assert property (
		cfg_wr |-> $past(wr && a == bit_error_tester_pkg::OFF_CFG_DATA)) else $error("spurious reconfiguration write");
	a_cfg_readback: assert property (
		rd && a == bit_error_tester_pkg::OFF_CFG_DATA |=> bus_rdata[15:0] == $past(cfg_rdata)) else $error("cfg read wrong");
	a_port_apply: assert property (
		wr && a == bit_error_tester_pkg::OFF_PORT_CTRL |=> port_ctrl == $past(bus_req.wdata[15:0])) else $error("port not set");
	a_pll_report: assert property (
		rd && a == bit_error_tester_pkg::OFF_GROUP_STAT && $stable(pll_locked) && !$past(srst)
		|=> bus_rdata[0] == $past(pll_locked)) else $error("pll lock misreported");
	a_rate_unlocked: assert property (
		$past(rd && a == 8'h48) && !bus_rdata[0] |-> bus_rdata[31:8] == 24'h00_0000) else $error("rate while unlocked");
	a_unmapped_zero: assert property (
		rd && (a inside {[8'h1c:8'h3f]} || a >= 8'hc0) |=> bus_rdata == 32'h0000_0000) else $error("hole not zero");
	a_rdata_quiet: assert property (
		!$past(rd) |-> bus_rdata == 32'h0000_0000) else $error("read data outside read slot");
endmodule

bind serial_link_bit_error_tester bit_error_tester_asserts #(.NUM_CH(NUM_CH), .MEAS_WIN_CYC(MEAS_WIN_CYC)) u_bit_error_tester_asserts (
	.clk(clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata), .pll_locked(pll_locked),
	.xcvr_stat(xcvr_stat), .xcvr_ctrl(xcvr_ctrl), .xcvr_reset(xcvr_reset), .cfg_wr(cfg_wr),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .port_ctrl(port_ctrl),
	.port_stat(port_stat));

// ==== tb_top.sv ====
// Self-checking bench for the bit error tester: register traffic, looped link, scoreboard of reads.
// Assumes the peer model stands in for the transceivers.
`timescale 1ns/1ps

module tb_top;
	// ==========
	// Bench
	typedef struct {
		string       name;
		logic [31:0] exp;
		logic [31:0] mask;
	} note_t;
	logic                       clk = 1'b0;
	logic                       srst = 1'b1;
	bit_error_tester_pkg::bus_req_t         bus_req = '0;
	logic                       pll_locked = 1'b1;
	logic [15:0]                port_stat = 16'h0000;
	logic [31:0]                bus_rdata;
	bit_error_tester_pkg::xcvr_stat_t [3:0] xcvr_stat;
	bit_error_tester_pkg::xcvr_ctrl_t [3:0] xcvr_ctrl;
	logic [3:0]                 xcvr_reset;
	logic                       cfg_wr;
	logic [5:0]                 cfg_addr;
	logic [15:0]                cfg_wdata;
	logic [15:0]                cfg_rdata;
	logic [15:0]                port_ctrl;
	note_t                      notes[$];
	note_t                      t;
	logic                       pend = 1'b0;
	int                         n_mismatch = 0;
	int                         total_checks = 0;
	integer                     seed = 65267;
	logic [31:0]                v;
	logic [31:0]                w;
	logic [7:0]                 b;
	always #5 clk = ~clk;

	serial_link_bit_error_tester #(.MEAS_WIN_CYC(100)) u_serial_link_bit_error_tester (
		.clk(clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata), .pll_locked(pll_locked),
		.xcvr_stat(xcvr_stat), .xcvr_ctrl(xcvr_ctrl), .xcvr_reset(xcvr_reset), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .port_ctrl(port_ctrl),
		.port_stat(port_stat));
	bit_error_tester_peer u_bit_error_tester_peer (.clk(clk), .xcvr_ctrl(xcvr_ctrl), .xcvr_reset(xcvr_reset), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .xcvr_stat(xcvr_stat), .cfg_rdata(cfg_rdata));

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		bus_req.wr    <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
		notes.push_back('{n, e, m});
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.rd   <= 1'b1;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(negedge clk);
		v = bus_rdata;
	endtask
	// Poll reads carry an empty mask; only the lock bit steers the loop.
	task automatic wait_lock(input logic [7:0] base);
		for (int i = 0; i < 200; i++) begin
			rd_reg(base + 8'h08, 32'h0000_0000, 32'h0000_0000, "lock poll");
			if (v[0] === 1'b1)
				return;
		end
		n_mismatch++;
		$display("wrong value lock expected 1 seen 0");
		complete_run();
	endtask

	// Read data stand one cycle after the strobe, so each note is settled at the next falling edge.
	always @(negedge clk) begin
		if (pend) begin
			t = notes.pop_front();
			total_checks++;
			if ((bus_rdata & t.mask) !== (t.exp & t.mask)) begin
				n_mismatch++;
				$display("wrong value %s expected %h seen %h", t.name, t.exp, bus_rdata);
			end
		end
		pend = bus_req.rd;
	end

	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		wr_reg(8'hc4, 32'hffff_ffff);
		rd_reg(8'h44, 32'h0000_0000, 32'hffff_ffff, "analog reset");
		rd_reg(8'h1c, 32'h0000_0000, 32'hffff_ffff, "hole");
		rd_reg(8'hc4, 32'h0000_0000, 32'hffff_ffff, "channel four");
		rd_reg(bit_error_tester_pkg::OFF_GROUP_STAT, 32'h0000_0001, 32'h0000_0001, "pll locked");
		@(posedge clk) pll_locked <= 1'b0;
		@(posedge clk);
		rd_reg(bit_error_tester_pkg::OFF_GROUP_STAT, 32'h0000_0000, 32'h0000_0001, "pll unlocked");
		$display("test reset and status done");
		for (int i = 0; i < 4; i++) begin
			w = $random(seed);
			wr_reg(8'h44, w);
			rd_reg(8'h44, w, 32'hffff_ffff, "analog");
			wr_reg(bit_error_tester_pkg::OFF_CFG_ADDR, w & 32'h0000_003f);
			wr_reg(bit_error_tester_pkg::OFF_CFG_DATA, w >> 16);
			rd_reg(bit_error_tester_pkg::OFF_CFG_DATA, w >> 16, 32'h0000_ffff, "cfg data");
			wr_reg(bit_error_tester_pkg::OFF_PORT_CTRL, w);
			@(posedge clk) port_stat <= w[31:16] ^ w[15:0];
			rd_reg(bit_error_tester_pkg::OFF_PORT_STAT, w ^ (w >> 16), 32'h0000_ffff, "port stat");
		end
		$display("test controls done");
		for (int p = 0; p < 6; p++) begin
			b = 8'h40 + 8'(p % 4) * 8'h20;
			w = (32'(p) << 8) | (32'(p) << 4) | 32'(p % 3);
			wr_reg(b, w);
			// A locked checker that changes sequence drops lock after a run of bad words; let that pass.
			repeat (32) @(posedge clk);
			wait_lock(b);
			wr_reg(b, w | 32'h0000_2000);
			rd_reg(b + 8'h0c, 32'h0000_0000, 32'h0000_0000, "bits poll");
			rd_reg(b + 8'h0c, v + 32'h0000_0040, 32'hffff_ffff, "bit count");
			wr_reg(b, w | 32'h0000_1000);
			repeat (8) @(posedge clk);
			rd_reg(b + 8'h14, 32'h0000_0001, 32'hffff_ffff, "one error");
			rd_reg(b + 8'h18, 32'h0000_0000, 32'hffff_ffff, "errors high");
			wr_reg(b, w | 32'h0000_2000);
			rd_reg(b + 8'h14, 32'h0000_0000, 32'hffff_ffff, "errors cleared");
			$display("test pattern %0d done", p);
		end
		rd_reg(8'h48, 32'h0000_1901, 32'hffff_ff01, "rx rate");
		rd_reg(8'h5c, 32'h0000_0032, 32'hffff_ffff, "tx rate");
		wr_reg(bit_error_tester_pkg::OFF_GROUP_CTRL, 32'h0000_0001);
		rd_reg(bit_error_tester_pkg::OFF_GROUP_STAT, 32'h0000_0002, 32'h0000_0002, "reset busy");
		rd_reg(8'h4c, 32'h0000_0000, 32'hffff_ffff, "bits in group reset");
		rd_reg(8'h48, 32'h0000_0000, 32'hffff_ffff, "lock in group reset");
		repeat (20) @(posedge clk);
		rd_reg(bit_error_tester_pkg::OFF_GROUP_STAT, 32'h0000_0000, 32'h0000_0002, "reset over");
		$display("test rates and group reset done");
		complete_run();
	end
endmodule
